// ===== hdl/prog_entry_and_addr_port.sv
// Programming entry sequencer and multiplexed EPROM address port
`timescale 1ns/1ps
module prog_entry_and_addr_port
   import prog_entry_pkg::*;
#(
   parameter logic [9:0] entry_key = 10'h2a5 // Arbitrary default key
) (
   input wire logic core_clk_in, // Crystal input clock, 10 MHz
   input wire logic rstn_in, // Asynchronous reset, active low
   input wire logic reset_pin_in, // External reset and key pin
   input wire logic address_byte_select_in, // Address byte select
   input wire logic verify_mode_in, // High: verify, low: program
   input wire logic [7:0] address_io_port_pins_in, // Address port level
   input wire logic [7:0] core_port_latch_in, // Port latch from core
   input wire logic [7:0] second_port_pins_in, // Second port level
   input wire logic [7:0] eprom_read_data_in, // Addressed EPROM byte
   output logic [7:0] address_io_port_pins_out, // Pin drive, low only
   output logic [7:0] address_io_port_pins_oe_out, // Pin drive enable
   output logic [7:0] second_port_pins_out, // Second port drive
   output logic [7:0] second_port_pins_oe_out, // Second port enable
   output logic [9:0] eprom_address_out, // Latched EPROM address
   output logic [7:0] eprom_write_data_out, // Byte to program
   output logic program_state_out, // Programming state reached
   output logic core_reset_out, // Device reset
   output logic [7:0] port_read_out, // Port levels to the core
   output alt_inputs_t alt_inputs_out // Alternate pin functions
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rst_sync, next_rst_sync;
   logic [1:0] sel_sync, next_sel_sync;
   logic [7:0] a_sync1, a_sync2, next_a_sync1, next_a_sync2;
   logic [7:0] s_sync1, s_sync2, next_s_sync1, next_s_sync2;

   // Second stage alone feeds logic; first stage is only for settling
   always_comb begin
      next_rst_sync = {rst_sync[0], reset_pin_in};
      next_sel_sync = {sel_sync[0], address_byte_select_in};
      next_a_sync1 = address_io_port_pins_in;
      next_a_sync2 = a_sync1;
      next_s_sync1 = second_port_pins_in;
      next_s_sync2 = s_sync1;
   end

   // Reset, select and both port pins settle through two stages before any logic sees them
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync <= 2'h0;
         sel_sync <= 2'h0;
         a_sync1 <= latch_reset_value;
         a_sync2 <= latch_reset_value;
         s_sync1 <= latch_reset_value;
         s_sync2 <= latch_reset_value;
      end else begin
         rst_sync <= next_rst_sync;
         sel_sync <= next_sel_sync;
         a_sync1 <= next_a_sync1;
         a_sync2 <= next_a_sync2;
         s_sync1 <= next_s_sync1;
         s_sync2 <= next_s_sync2;
      end
   end

   // Settled pin levels seen by the entry and address logic
   logic rst_level;
   logic sel_level;
   assign rst_level = rst_sync[1];
   assign sel_level = sel_sync[1];

   // ----------------------------------------------------------------
   // Reset detection and serial key entry
   // ----------------------------------------------------------------
   entry_state_t state, next_state;
   logic [4:0] hold_count, next_hold_count;
   logic [3:0] bit_count, next_bit_count;
   logic [9:0] key_shift, next_key_shift;
   logic core_reset, next_core_reset;

   // Key bits come in LSB first, so each one enters at the top
   always_comb begin
      next_state = state;
      next_hold_count = hold_count;
      next_bit_count = bit_count;
      next_key_shift = key_shift;
      next_core_reset = core_reset;
      if (!rst_level) begin
         next_hold_count = hold_count_reset;
      end else if (hold_count != 5'(reset_hold_clocks)) begin
         next_hold_count = hold_count + 5'h01;
      end
      unique case (state)
         st_run, st_program: begin
            // High held long enough restarts entry from run or program state
            if (rst_level && hold_count == 5'(reset_hold_clocks - 1)) begin
               next_state = st_in_reset; // RULE4
               next_core_reset = 1'b1; // RULE4
            end
         end
         st_in_reset: begin
            // First low after the hold starts the key; one bit a clock
            if (!rst_level) begin
               next_state = st_shift;
               next_core_reset = 1'b0;
               next_bit_count = bit_count_reset;
               next_key_shift = key_reset_value;
            end
         end
         st_shift: begin
            next_key_shift = {rst_level, key_shift[9:1]}; // RULE5 RULE6
            next_bit_count = bit_count + 4'h1; // RULE6
            if (bit_count == 4'(key_width - 1)) begin
               if ({rst_level, key_shift[9:1]} == entry_key) begin
                  next_state = st_program; // RULE5
               end else begin
                  next_state = st_run;
               end
            end
         end
      endcase
   end

   // Entry state registers; a hard reset leaves the core running
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= st_run;
         hold_count <= hold_count_reset;
         bit_count <= bit_count_reset;
         key_shift <= key_reset_value;
         core_reset <= 1'b0;
      end else begin
         state <= next_state;
         hold_count <= next_hold_count;
         bit_count <= next_bit_count;
         key_shift <= next_key_shift;
         core_reset <= next_core_reset;
      end
   end

   // ----------------------------------------------------------------
   // Address latch and data path
   // ----------------------------------------------------------------
   logic [9:0] eprom_addr, next_eprom_addr;
   logic [7:0] wr_data, next_wr_data;
   // Program state gates the address latch and the pin drivers
   logic prog_active;
   assign prog_active = (state == st_program);

   // Address follows the port while in programming state
   always_comb begin
      next_eprom_addr = eprom_addr;
      next_wr_data = wr_data;
      if (prog_active) begin
         if (!sel_level) begin
            next_eprom_addr[7:0] = a_sync2; // RULE3 RULE10
         end else begin
            next_eprom_addr[9:8] = a_sync2[high_addr_bits-1:0]; // RULE12
         end
         if (!verify_mode_in) begin
            next_wr_data = s_sync2; // RULE11
         end
      end
   end

   // Address and write byte registers
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         eprom_addr <= addr_reset_value;
         wr_data <= latch_reset_value;
      end else begin
         eprom_addr <= next_eprom_addr;
         wr_data <= next_wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers and registered outputs
   // ----------------------------------------------------------------
   logic [7:0] next_a_oe, next_s_out, next_s_oe;
   alt_inputs_t next_alt;

   // Pull-ups give the high; only a zero latch drives, so ones read back
   always_comb begin
      next_a_oe = prog_active ? 8'h00 : ~core_port_latch_in; // RULE1 RULE2
      next_s_out = 8'h00;
      next_s_oe = 8'h00;
      if (prog_active && verify_mode_in) begin
         next_s_out = eprom_read_data_in; // RULE11
         next_s_oe = 8'hff; // RULE11
      end
      next_alt.ext_irq_zero = s_sync2[irq0_bit]; // RULE7
      next_alt.ext_irq_one = s_sync2[irq1_bit]; // RULE8
      next_alt.timer_zero_count_input = s_sync2[timer0_bit]; // RULE9
   end

   // Every output leaves from a flop so the pins never glitch
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         address_io_port_pins_out <= 8'h00;
         address_io_port_pins_oe_out <= 8'h00;
         second_port_pins_out <= 8'h00;
         second_port_pins_oe_out <= 8'h00;
         eprom_address_out <= addr_reset_value;
         eprom_write_data_out <= latch_reset_value;
         program_state_out <= 1'b0;
         core_reset_out <= 1'b0;
         port_read_out <= latch_reset_value;
         alt_inputs_out <= '1;
      end else begin
         address_io_port_pins_out <= 8'h00;
         address_io_port_pins_oe_out <= next_a_oe;
         second_port_pins_out <= next_s_out;
         second_port_pins_oe_out <= next_s_oe;
         eprom_address_out <= eprom_addr;
         eprom_write_data_out <= wr_data;
         program_state_out <= prog_active;
         core_reset_out <= core_reset;
         port_read_out <= a_sync2; // RULE2
         alt_inputs_out <= next_alt;
      end
   end

endmodule

// ===== hdl/prog_entry_pkg.sv
// Constants and carrier types for the programming entry and address port
// -------------------------------------------------------------------------
// Operation
// RULE1: Eight-bit bidirectional address port, every pin with a pull-up.
// RULE2: Pin with latch at one is only pulled up, readable as input.
// RULE3: In programming mode the port takes the ten-bit EPROM address.
// RULE4: Reset pin high for two machine cycles resets the device.
// RULE5: After reset a ten-bit key, LSB first, enters programming state.
// RULE6: Key bits are sampled on the crystal clock, sent in step with it.
// RULE7: Second port bit five doubles as external interrupt zero input.
// RULE8: Second port bit six doubles as external interrupt one input.
// RULE9: Second port bit seven doubles as timer zero count input.
// RULE10: Select low latches the port byte as the low address byte.
// RULE11: Verify drives EPROM byte onto second port; program reads it.
// RULE12: Select high takes upper address from two low port pins.
// -------------------------------------------------------------------------
package prog_entry_pkg;
   localparam int port_width = 8;
   localparam int addr_width = 10;
   localparam int key_width = 10;
   localparam int clocks_per_machine_cycle = 12;
   localparam int reset_machine_cycles = 2;
   localparam int reset_hold_clocks =
      clocks_per_machine_cycle * reset_machine_cycles;
   localparam int high_addr_bits = addr_width - port_width;
   localparam logic [9:0] key_reset_value = 10'h000;
   localparam logic [7:0] latch_reset_value = 8'hff;
   localparam logic [9:0] addr_reset_value = 10'h000;
   localparam logic [4:0] hold_count_reset = 5'h00;
   localparam logic [3:0] bit_count_reset = 4'h0;
   localparam int irq0_bit = 5;
   localparam int irq1_bit = 6;
   localparam int timer0_bit = 7;

   typedef enum logic [1:0] {st_run, st_in_reset, st_shift, st_program}
      entry_state_t;

   typedef struct packed {
      logic ext_irq_zero;
      logic ext_irq_one;
      logic timer_zero_count_input;
   } alt_inputs_t;
endpackage

// ===== bench/prog_entry_properties.sv
// Timing checks on the programming entry and address port outputs
`timescale 1ns/1ps
module prog_entry_properties (
   input wire logic core_clk_in, // Clock
   input wire logic rstn_in, // Reset, active low
   input wire logic reset_pin_in, // Reset and key pin
   input wire logic [7:0] core_port_latch_in, // Port latch
   input wire logic [7:0] eprom_read_data_in, // EPROM byte
   input wire logic [7:0] address_io_port_pins_out, // Pin drive
   input wire logic [7:0] address_io_port_pins_oe_out, // Pin enable
   input wire logic [7:0] second_port_pins_out, // Second port drive
   input wire logic [7:0] second_port_pins_oe_out, // Second port enable
   input wire logic program_state_out, // Programming state
   input wire logic core_reset_out // Device reset
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   // Port only ever pulls low; highs come from the pull-ups
   a_pins_low_only: assert property (
      address_io_port_pins_out == 8'h00)
      else $error("address port drove a high");
   // Outside programming the enable is the inverted core latch
   a_oe_from_latch: assert property (
      !program_state_out && $past(rstn_in)
      |-> address_io_port_pins_oe_out == ~$past(core_port_latch_in))
      else $error("port enable not the inverted latch");
   a_oe_in_prog: assert property (program_state_out
      |-> address_io_port_pins_oe_out == 8'h00)
      else $error("address port driven in programming state");
   a_oe_whole_port: assert property (
      second_port_pins_oe_out == 8'h00 || second_port_pins_oe_out == 8'hff)
      else $error("second port enable split");
   a_verify_data: assert property (second_port_pins_oe_out[0]
      |-> second_port_pins_out == $past(eprom_read_data_in))
      else $error("verify byte not on second port");
   a_reset_hold: assert property ($rose(core_reset_out)
      |-> $past(reset_pin_in, 24) && $past(reset_pin_in, 2))
      else $error("reset taken on a short hold");
   a_reset_exits: assert property ($rose(core_reset_out)
      |=> !program_state_out)
      else $error("programming state kept over reset");
   a_prog_leave: assert property ($fell(program_state_out)
      |-> core_reset_out || $past(core_reset_out))
      else $error("programming state left without reset");
endmodule

// ===== bench/prog_programmer_model.sv
// External programmer: reset key sender and address port driver
`timescale 1ns/1ps
module prog_programmer_model (
   input wire logic clk_in, // Crystal clock
   input wire logic [7:0] dev_oe_in, // Device pin enables
   input wire logic [7:0] dev_out_in, // Device pin drive
   output logic reset_pin_out, // Reset and key pin
   output logic sel_out, // Address byte select
   output logic [7:0] port_out // Resolved port level
);
   logic [7:0] val = 8'h00;
   logic [7:0] en = 8'h00;
   // Released pins float up through the pull-ups
   assign port_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & en & val) |
      (~dev_oe_in & ~en);
   initial begin
      reset_pin_out = 1'b0;
      sel_out = 1'b0;
   end
   // Hold high, one idle low clock, then key LSB first, all on clock falls
   task automatic enter(input int hold, input logic [9:0] key);
      @(negedge clk_in) reset_pin_out = 1'b1;
      repeat (hold) @(negedge clk_in);
      reset_pin_out = 1'b0;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_in) reset_pin_out = key[i];
      end
      @(negedge clk_in) reset_pin_out = 1'b0;
   endtask
   // Present one address portion under the byte select
   task automatic put_addr(input logic s, input logic [7:0] v);
      @(negedge clk_in) sel_out = s;
      en = 8'hff;
      val = v;
      repeat (6) @(negedge clk_in);
   endtask
endmodule

// ===== bench/prog_entry_and_addr_port_bench.sv
// Self-checking bench for the programming entry and address port
`timescale 1ns/1ps
module prog_entry_and_addr_port_bench;
   import prog_entry_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, rpin, sel, vfy = 1'b0;
   logic [7:0] pins, latch = 8'h0f, sp = 8'h00, rd = 8'h00;
   logic [7:0] po, poe, so, soe, wd, prd;
   logic [9:0] addr;
   logic prog, crst;
   alt_inputs_t alt;
   int fails = 0, samples_checked = 0;
   prog_entry_and_addr_port uut (.core_clk_in(clk), .rstn_in(rstn),
      .reset_pin_in(rpin), .address_byte_select_in(sel),
      .verify_mode_in(vfy), .address_io_port_pins_in(pins),
      .core_port_latch_in(latch), .second_port_pins_in(sp),
      .eprom_read_data_in(rd), .address_io_port_pins_out(po),
      .address_io_port_pins_oe_out(poe), .second_port_pins_out(so),
      .second_port_pins_oe_out(soe), .eprom_address_out(addr),
      .eprom_write_data_out(wd), .program_state_out(prog),
      .core_reset_out(crst), .port_read_out(prd), .alt_inputs_out(alt));
   prog_programmer_model pm (.clk_in(clk), .dev_oe_in(poe),
      .dev_out_in(po), .reset_pin_out(rpin), .sel_out(sel),
      .port_out(pins));
   initial forever #50 clk = ~clk;
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d, failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Short hold and wrong key must both be refused
   task automatic refusals();
      pm.enter(20, 10'h2a5);
      repeat (20) @(negedge clk);
      check(prog, 1'b0);
      pm.enter(30, 10'h2a4);
      repeat (20) @(negedge clk);
      check(prog, 1'b0);
   endtask
   // Good key, bounded wait; device reset must stand during the hold
   task automatic good_entry();
      fork
         pm.enter(30, 10'h2a5);
         begin
            repeat (29) @(negedge clk);
            check(crst, 1'b1);
         end
      join
      for (int i = 0; i < 40 && prog !== 1'b1; i++) @(negedge clk);
      check(prog, 1'b1);
      if (prog !== 1'b1) finish_test();
      check(poe, 8'h00);
      check(crst, 1'b0);
   endtask
   // Idle port reads back pull-ups and latch lows, then the driven byte once the latch is all ones
   task automatic idle_port();
      repeat (4) @(negedge clk);
      check(prd, 8'h0f);
      pm.put_addr(1'b0, 8'ha5);
      check(prd, 8'h05);
      latch = 8'hff;
      repeat (5) @(negedge clk);
      check(poe, 8'h00);
      check(prd, 8'ha5);
   endtask
   // Address halves, write byte and alternate inputs in program mode
   task automatic program_path();
      pm.put_addr(1'b0, 8'h5c);
      pm.put_addr(1'b1, 8'hfe);
      check(addr, 10'h25c);
      sp = 8'ha0; // Bits 5 and 7 high
      repeat (5) @(negedge clk);
      check(wd, 8'ha0);
      check(alt, 3'h5);
      sp = 8'h40;
      repeat (5) @(negedge clk);
      check(alt, 3'h2);
   endtask
   // Verify drives the byte out; a new hold leaves the state
   task automatic verify_and_exit();
      vfy = 1'b1;
      rd = 8'hc3;
      repeat (3) @(negedge clk);
      check(so, 8'hc3);
      check(soe, 8'hff);
      pm.enter(30, 10'h000);
      repeat (20) @(negedge clk);
      check(prog, 1'b0);
      check(soe, 8'h00);
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      idle_port();
      refusals();
      good_entry();
      program_path();
      verify_and_exit();
      finish_test();
   end
endmodule
bind prog_entry_and_addr_port prog_entry_properties chk (.core_clk_in,
   .rstn_in, .reset_pin_in, .core_port_latch_in, .eprom_read_data_in,
   .address_io_port_pins_out, .address_io_port_pins_oe_out,
   .second_port_pins_out, .second_port_pins_oe_out, .program_state_out,
   .core_reset_out);
